/* design/tou_cmp.sv */
// Purpose: compares system time against a target time
// Assumes: nanoseconds below one second, both inputs on the same clock
// Notes: purely combinational; the caller registers the result
module tou_cmp (
  // times
  input  wire tou_pkg::tou_time_s now_t,
  input  wire tou_pkg::tou_time_s tgt_t,
  // results
  output logic                    reached,
  output logic                    passed
);
  import tou_pkg::*;

  function automatic logic later(input tou_time_s a, input tou_time_s b);
    later = (a.sec > b.sec) || ((a.sec == b.sec) && (a.ns > b.ns));
  endfunction

  always_comb begin
    passed  = later(now_t, tgt_t);
    reached = passed || (now_t == tgt_t);
  end

endmodule

/* design/tou_pkg.sv */
// Purpose: constants and types for one timed output unit (target time and cascade)
// Assumes: 16-bit register port, system time supplied on ref_clk
// Notes: register offsets are byte addresses of the host register space
package tou_pkg;

  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 16;
  localparam int NUNITS  = 12;
  localparam int NS_W    = 30;
  localparam int SEC_W   = 32;
  localparam int NSHI_W  = 14;
  localparam int SEL_W   = 4;

  localparam logic [ADDR_W-1:0] OFF_ENABLE = 12'h206;
  localparam logic [ADDR_W-1:0] OFF_SRST   = 12'h208;
  localparam logic [ADDR_W-1:0] OFF_NS_LO  = 12'h220;
  localparam logic [ADDR_W-1:0] OFF_NS_HI  = 12'h222;
  localparam logic [ADDR_W-1:0] OFF_S_LO   = 12'h224;
  localparam logic [ADDR_W-1:0] OFF_S_HI   = 12'h226;
  localparam logic [ADDR_W-1:0] OFF_CFG1   = 12'h228;

  localparam int CFG_CASC_BIT  = 15;
  localparam int CFG_TAIL_BIT  = 14;
  localparam int CFG_SEL_HI    = 13;
  localparam int CFG_SEL_LO    = 10;
  localparam int CFG_NOW_BIT   = 9;

  localparam logic [SEL_W-1:0]  SEL_RST    = 4'hf;
  localparam logic [SEL_W-1:0]  SEL_MAXVAL = 4'hb;
  localparam logic [DATA_W-1:0] WORD_RST   = 16'h0000;
  localparam logic [NSHI_W-1:0] NSHI_RST   = 14'h0000;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tou_bus_s;

  typedef struct packed {
    logic [SEC_W-1:0] sec;
    logic [NS_W-1:0]  ns;
  } tou_time_s;

  typedef enum logic [1:0] {
    TOU_IDLE,
    TOU_WAIT_UP,
    TOU_ARMED
  } tou_st_e;

endpackage

/* design/tou_unit.sv */
// Purpose: one timed output unit: target time registers and cascade control
// Assumes: system time, upstream fire events and iteration end come from ref_clk logic
// Notes: only this unit's bit of the shared enable and soft reset words lives here
module tou_unit #(
  parameter int UNIT_IDX = 0
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  // register port
  input  wire tou_pkg::tou_bus_s          bus,
  output logic [tou_pkg::DATA_W-1:0]      rd_data,
  // time and cascade chain
  input  wire tou_pkg::tou_time_s         sys_time,
  input  wire logic [tou_pkg::NUNITS-1:0] up_fire,
  input  wire logic                       iter_last,
  // unit state
  output logic                            fire,
  output logic                            armed,
  output logic                            late,
  output logic                            casc_on
);
  import tou_pkg::*;

  typedef struct packed {
    tou_st_e           st;
    logic [DATA_W-1:0] ns_lo;
    logic [NSHI_W-1:0] ns_hi;
    logic [DATA_W-1:0] s_lo;
    logic [DATA_W-1:0] s_hi;
    logic              casc;
    logic              tail;
    logic [SEL_W-1:0]  up_sel;
    logic              now_en;
    logic              en;
    logic              late;
    logic              fire;
    logic              stop;
    logic [DATA_W-1:0] rdata;
  } tou_regs_s;

  localparam tou_regs_s REGS_RST = '{
    st:     TOU_IDLE,
    ns_lo:  WORD_RST,
    ns_hi:  NSHI_RST,
    s_lo:   WORD_RST,
    s_hi:   WORD_RST,
    casc:   1'b0,
    tail:   1'b0,
    up_sel: SEL_RST,
    now_en: 1'b0,
    en:     1'b0,
    late:   1'b0,
    fire:   1'b0,
    stop:   1'b0,
    rdata:  WORD_RST
  };

  initial begin
    if (UNIT_IDX < 0 || UNIT_IDX >= NUNITS) begin
      $error("UNIT_IDX out of range");
    end
  end

  tou_regs_s q_r;
  tou_regs_s q_nxt;

  tou_time_s tgt;
  logic      t_reached;
  logic      t_passed;
  logic      wr_en;
  logic      wr_srst;
  logic      wr_nsl;
  logic      wr_nsh;
  logic      wr_sl;
  logic      wr_sh;
  logic      wr_cfg;
  logic      up_hit;
  logic      go;

  assign tgt.ns  = {q_r.ns_hi, q_r.ns_lo};
  assign tgt.sec = {q_r.s_hi, q_r.s_lo};

  tou_cmp u_cmp (
    .now_t   (sys_time),
    .tgt_t   (tgt),
    .reached (t_reached),
    .passed  (t_passed)
  );

  function automatic logic hit(input tou_bus_s b, input logic [ADDR_W-1:0] off);
    hit = b.wr && (b.addr == off);
  endfunction

  function automatic logic [DATA_W-1:0] rd_mux(input tou_regs_s s,
                                              input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = WORD_RST;
    unique case (a)
      OFF_ENABLE: v[UNIT_IDX] = s.en;
      OFF_NS_LO:  v = s.ns_lo;
      OFF_NS_HI:  v[NSHI_W-1:0] = s.ns_hi;
      OFF_S_LO:   v = s.s_lo;
      OFF_S_HI:   v = s.s_hi;
      OFF_CFG1: begin
        v[CFG_CASC_BIT]              = s.casc;
        v[CFG_TAIL_BIT]              = s.tail;
        v[CFG_SEL_HI:CFG_SEL_LO]     = s.up_sel;
        v[CFG_NOW_BIT]               = s.now_en;
      end
      // soft reset self-clears, so it always reads zero
      default:    v = WORD_RST;
    endcase
    rd_mux = v;
  endfunction

  always_comb begin
    wr_en   = hit(bus, OFF_ENABLE) && bus.wdata[UNIT_IDX];
    wr_srst = hit(bus, OFF_SRST) && bus.wdata[UNIT_IDX];
    wr_nsl  = hit(bus, OFF_NS_LO);
    wr_nsh  = hit(bus, OFF_NS_HI);
    wr_sl   = hit(bus, OFF_S_LO);
    wr_sh   = hit(bus, OFF_S_HI);
    wr_cfg  = hit(bus, OFF_CFG1);
    up_hit  = (q_r.up_sel <= SEL_MAXVAL) && up_fire[q_r.up_sel];
    // late target fires only with bit set
    go      = t_reached && (!q_r.late || q_r.now_en);
  end

  always_comb begin
    q_nxt       = q_r;
    q_nxt.fire  = 1'b0;
    q_nxt.rdata = bus.rd ? rd_mux(q_r, bus.addr) : WORD_RST;

    if (wr_nsl) begin
      q_nxt.ns_lo = bus.wdata;
    end
    if (wr_nsh) begin
      q_nxt.ns_hi = bus.wdata[NSHI_W-1:0];
    end
    if (wr_sl) begin
      q_nxt.s_lo = bus.wdata;
    end
    if (wr_sh) begin
      q_nxt.s_hi = bus.wdata;
    end
    if (wr_cfg) begin
      q_nxt.casc   = bus.wdata[CFG_CASC_BIT];
      q_nxt.tail   = bus.wdata[CFG_TAIL_BIT];
      q_nxt.up_sel = bus.wdata[CFG_SEL_HI:CFG_SEL_LO];
      q_nxt.now_en = bus.wdata[CFG_NOW_BIT];
      // a fresh setup restarts a chain that the tail has stopped
      q_nxt.stop   = 1'b0;
    end

    unique case (q_r.st)
      TOU_IDLE: begin
        if (q_r.en) begin
          q_nxt.st   = TOU_ARMED;
          q_nxt.late = t_passed;
        end else if (q_r.casc && !q_r.stop) begin
          q_nxt.st = TOU_WAIT_UP;
        end
      end
      TOU_WAIT_UP: begin
        // ring order relies on software setup
        if (q_r.en || up_hit) begin
          q_nxt.st   = TOU_ARMED;
          q_nxt.late = t_passed;
        end else if (!q_r.casc) begin
          q_nxt.st = TOU_IDLE;
        end
      end
      TOU_ARMED: begin
        if (go) begin
          q_nxt.fire = 1'b1;
          q_nxt.en   = 1'b0;
          q_nxt.late = 1'b0;
          if (q_r.casc && !(q_r.tail && iter_last)) begin
            q_nxt.st = TOU_WAIT_UP;
          end else begin
            q_nxt.st   = TOU_IDLE;
            // tail ends the chain; idle must not rejoin the wait
            q_nxt.stop = q_r.casc;
          end
        end
      end
    endcase

    // set wins over the self-clear above
    if (wr_en) begin
      q_nxt.en   = 1'b1;
      q_nxt.stop = 1'b0;
    end

    if (wr_srst) begin
      q_nxt       = REGS_RST;
      q_nxt.rdata = bus.rd ? rd_mux(q_r, bus.addr) : WORD_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q_r <= REGS_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // armed is a state decode, so it gets its own flop to stay registered
  logic armed_r;
  logic late_r;
  logic casc_r;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      armed_r <= 1'b0;
      late_r  <= 1'b0;
      casc_r  <= 1'b0;
    end else begin
      armed_r <= (q_nxt.st == TOU_ARMED);
      late_r  <= q_nxt.late;
      casc_r  <= q_nxt.casc;
    end
  end

  assign rd_data = q_r.rdata;
  assign fire    = q_r.fire;
  assign armed   = armed_r;
  assign late    = late_r;
  assign casc_on = casc_r;

endmodule

/* testbench/tou_unit_properties.sv */
// Purpose: port checks for one timed output unit
// Assumes: bound to tou_unit with the same UNIT_IDX
// Notes: enable check skips cascade, which arms from upstream
module tou_unit_properties #(
  parameter int UNIT_IDX = 0
) (
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       nrst,
  // register port
  input wire tou_pkg::tou_bus_s          bus,
  input wire logic [tou_pkg::DATA_W-1:0] rd_data,
  // unit state
  input wire logic                       fire,
  input wire logic                       armed,
  input wire logic                       late,
  input wire logic                       casc_on
);
  timeunit 1ns;
  timeprecision 100ps;
  import tou_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_nshi_top_zero: assert property ($past(bus.rd) && $past(bus.addr) == OFF_NS_HI
    |-> rd_data[15:14] == 2'h0) else $error("reserved ns bits not zero");
  a_casc_bit_write: assert property ($past(bus.wr) && $past(bus.addr) == OFF_CFG1
    |-> casc_on == $past(bus.wdata[CFG_CASC_BIT])) else $error("cascade bit wrong");
  a_cfg_low_zero: assert property ($past(bus.rd) && $past(bus.addr) == OFF_CFG1
    |-> rd_data[8:0] == 9'h000) else $error("unused config bits not zero");
  a_late_is_armed: assert property (late |-> armed) else $error("late while not armed");
  a_fire_from_armed: assert property (fire |-> $past(armed))
    else $error("fire without arming");
  a_fire_one_cycle: assert property (fire |=> !fire) else $error("fire longer than one cycle");
  a_enable_arms: assert property ($past(bus.wr) && $past(bus.addr) == OFF_ENABLE
    && $past(bus.wdata[UNIT_IDX]) && !casc_on |-> ##1 armed) else $error("enable did not arm");
  a_srst_idle: assert property ($past(bus.wr) && $past(bus.addr) == OFF_SRST
    && $past(bus.wdata[UNIT_IDX]) |-> !armed && !casc_on && !fire) else $error("not idle");
  a_rd_idle_zero: assert property (!$past(bus.rd) |-> rd_data == 16'h0000)
    else $error("read data outside answer cycle");
  c_fire: cover property (fire);
  c_late: cover property (late);
  c_casc_fire: cover property (fire && casc_on);
endmodule

/* testbench/tou_unit_tb.sv */
// Purpose: self-checking bench for one timed output unit
// Assumes: UNIT_IDX 0, system time steps 1 ns per cycle
// Notes: bus tasks leave a spare cycle between strobes
module tou_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tou_pkg::*;
  logic              ref_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              iter_last = 1'b0;
  tou_bus_s          bus = '0;
  tou_time_s         sys_time = '{sec: 32'h5, ns: 30'h0};
  logic [NUNITS-1:0] up_fire = '0;
  logic [DATA_W-1:0] rd_data, d;
  logic              fire, armed, late, casc_on, s;
  logic [NS_W-1:0]   t;
  int                num_errors = 0, check_count = 0, seed = 44545, k;
  logic [ADDR_W-1:0] am [4] = '{OFF_NS_HI, OFF_S_LO, OFF_S_HI, OFF_CFG1};
  logic [DATA_W-1:0] mk [4] = '{16'h3fff, 16'hffff, 16'hffff, 16'hfe00};
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) sys_time.ns <= sys_time.ns + 30'h1;
  tou_unit #(.UNIT_IDX(0)) i_tou_unit (.ref_clk(ref_clk), .nrst(nrst), .bus(bus),
    .rd_data(rd_data), .sys_time(sys_time), .up_fire(up_fire), .iter_last(iter_last),
    .fire(fire), .armed(armed), .late(late), .casc_on(casc_on));
  task chk(input logic [DATA_W-1:0] g, e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ref_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge ref_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 chk(rd_data, e);
  endtask
  // no early exit: a no-fire case needs the whole window anyway
  task wf(input int n);
    s = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      if (fire === 1'b1 && !s) begin
        s = 1'b1;
        t = sys_time.ns;
      end
    end
  endtask
  task tgt(input logic [SEC_W-1:0] sc, input logic [NS_W-1:0] n);
    wr(OFF_NS_LO, n[15:0]);
    wr(OFF_NS_HI, {2'h0, n[29:16]});
    wr(OFF_S_LO, sc[15:0]);
    wr(OFF_S_HI, sc[31:16]);
  endtask
  task pulse(input logic [NUNITS-1:0] p);
    @(posedge ref_clk);
    up_fire <= p;
    @(posedge ref_clk);
    up_fire <= '0;
  endtask
  task end_of_test;
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge ref_clk);
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(OFF_NS_HI, 16'h0000);
    rd(OFF_S_LO, 16'h0000);
    rd(OFF_S_HI, 16'h0000);
    rd(OFF_CFG1, 16'h3c00);
    repeat (24) begin
      k = $unsigned($random(seed)) % 4;
      d = $random(seed);
      wr(am[k], d);
      rd(am[k], d & mk[k]);
    end
    wr(12'h230, 16'hffff);
    rd(12'h230, 16'h0000);
    wr(OFF_SRST, 16'h0001);
    rd(OFF_CFG1, 16'h3c00);
    // equal time counts as reached: fire shows at the edge that sees ns equal to target
    t = sys_time.ns + 30'd60;
    k = int'(t) + 1;
    tgt(32'h5, t);
    wr(OFF_ENABLE, 16'h0001);
    wf(90);
    chk(16'(s), 16'h1);
    chk(16'(t), 16'(k));
    rd(OFF_ENABLE, 16'h0000);
    tgt(32'h4, 30'h0);
    wr(OFF_ENABLE, 16'h0001);
    wf(20);
    chk(16'(s), 16'h0);
    chk(16'(late), 16'h1);
    wr(OFF_SRST, 16'h0001);
    #1 chk(16'(armed), 16'h0);
    tgt(32'h4, 30'h0);
    wr(OFF_CFG1, 16'h0200);
    wr(OFF_ENABLE, 16'h0001);
    wf(10);
    chk(16'(s), 16'h1);
    wr(OFF_SRST, 16'h0001);
    wr(OFF_CFG1, 16'h8a00);
    #1 chk(16'(casc_on), 16'h1);
    pulse(12'h008);
    wf(8);
    chk(16'(s), 16'h0);
    repeat (2) begin
      pulse(12'h004);
      wf(8);
      chk(16'(s), 16'h1);
    end
    @(posedge ref_clk) iter_last <= 1'b1;
    wr(OFF_CFG1, 16'hca00);
    pulse(12'h004);
    wf(8);
    chk(16'(s), 16'h1);
    pulse(12'h004);
    wf(8);
    chk(16'(s), 16'h0);
    wr(OFF_SRST, 16'h0001);
    wr(OFF_CFG1, 16'hb200);
    pulse(12'hfff);
    wf(8);
    chk(16'(s), 16'h0);
    end_of_test;
  end
endmodule
bind tou_unit tou_unit_properties #(.UNIT_IDX(UNIT_IDX)) i_tou_unit_properties (
  .ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rd_data(rd_data), .fire(fire),
  .armed(armed), .late(late), .casc_on(casc_on));
